// ===== src/ppc_top.sv
`timescale 1ns/1ps
`include "ppc_regs.svh"

// Notes on behaviour
// - group 1 third port all input when control bits 3 and 0 set
// - group 1 third port latched output when bits 3, 2, 0 cleared
// - 8-bit third port: lines 0 and 3 data, port interrupts cut
// - group 2 first port input with control bit 4 set
// - group 2 first port latched output with control bit 4 clear
// - group 2 second port at E9, mode 0 selected by bit 2 clear
// - group 2 port directions independent of each other
// - group 2 third port: all in, all out, or nibble split
// - group 2 third port all input with bits 3 and 0 set
// - group 2 third port latched output with bits 3 and 0 clear
// - bit 3 set, bit 0 clear: upper nibble in, lower out
// - bit 3 clear, bit 0 set: upper nibble out, lower in
// - group 2 first and second ports offer only mode 0

module ppc_top #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,          // system clock
    input  wire logic             sys_rst,      // sync reset, high
    input  ppc_pkg::ppc_byte_t    io_addr,      // i/o port address
    input  wire logic             io_rd,        // read strobe
    input  wire logic             io_wr,        // write strobe
    input  ppc_pkg::ppc_byte_t    io_wdata,     // write data
    output ppc_pkg::ppc_byte_t    io_rdata,     // read data
    output logic                  io_rvalid,    // read data valid
    input  wire logic [WIDTH-1:0] g1_first_in,  // group 1 first pins
    output logic      [WIDTH-1:0] g1_first_out, // group 1 first latch
    output logic      [WIDTH-1:0] g1_first_oe,  // group 1 first drive
    input  wire logic [WIDTH-1:0] g1_second_in, // group 1 second pins
    output logic      [WIDTH-1:0] g1_second_out,// group 1 second latch
    output logic      [WIDTH-1:0] g1_second_oe, // group 1 second drive
    input  wire logic [WIDTH-1:0] g1_third_in,  // group 1 third pins
    output logic      [WIDTH-1:0] g1_third_out, // group 1 third latch
    output logic      [WIDTH-1:0] g1_third_oe,  // group 1 third drive
    input  wire logic [WIDTH-1:0] g2_first_in,  // group 2 first pins
    output logic      [WIDTH-1:0] g2_first_out, // group 2 first latch
    output logic      [WIDTH-1:0] g2_first_oe,  // group 2 first drive
    input  wire logic [WIDTH-1:0] g2_second_in, // group 2 second pins
    output logic      [WIDTH-1:0] g2_second_out,// group 2 second latch
    output logic      [WIDTH-1:0] g2_second_oe, // group 2 second drive
    input  wire logic [WIDTH-1:0] g2_third_in,  // group 2 third pins
    output logic      [WIDTH-1:0] g2_third_out, // group 2 third latch
    output logic      [WIDTH-1:0] g2_third_oe,  // group 2 third drive
    output logic                  third_full_path,     // 8-bit data path
    output logic                  third_port_line_zero, // line 0 is data
    output logic                  third_port_line_three,// line 3 is data
    output logic                  first_irq_connect,   // port 1 irq routed
    output logic                  second_irq_connect   // port 2 irq routed
);
    import ppc_pkg::*;

    localparam int NPORT = 6;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic ppc_sel_e reg_decode(input ppc_byte_t addr);
        ppc_sel_e sel;
        sel = PPC_SEL_NONE;
        if (addr == `PPC_G1_FIRST_OFF) begin
            sel = PPC_SEL_G1_FIRST;
        end else if (addr == `PPC_G1_SECOND_OFF) begin
            sel = PPC_SEL_G1_SECOND;
        end else if (addr == `PPC_G1_THIRD_OFF) begin
            sel = PPC_SEL_G1_THIRD;
        end else if (addr == `PPC_G1_CTRL_OFF) begin
            sel = PPC_SEL_G1_CTRL;
        end else if (addr == `PPC_G2_FIRST_OFF) begin
            sel = PPC_SEL_G2_FIRST;
        end else if (addr == `PPC_G2_SECOND_OFF) begin
            sel = PPC_SEL_G2_SECOND;
        end else if (addr == `PPC_G2_THIRD_OFF) begin
            sel = PPC_SEL_G2_THIRD;
        end else if (addr == `PPC_G2_CTRL_OFF) begin
            sel = PPC_SEL_G2_CTRL;
        end
        return sel;
    endfunction

    // one mask per port; 1 marks an input bit
    function automatic logic [WIDTH-1:0] dir_fill(input logic is_in);
        return is_in ? {WIDTH{1'b1}} : {WIDTH{1'b0}};
    endfunction

    // apply a bit set/reset command to a third-port latch
    function automatic logic [WIDTH-1:0] bit_cmd(
        input logic [WIDTH-1:0] cur,
        input ppc_byte_t        cmd
    );
        logic [WIDTH-1:0] res;
        logic [2:0]       idx;
        res = cur;
        idx = cmd[`PPC_CW_BSR_SEL_HI:`PPC_CW_BSR_SEL_LO];
        res[idx] = cmd[`PPC_CW_BSR_VAL];
        return res;
    endfunction

    ppc_access_e acc;
    ppc_sel_e    sel;

    // a write wins when both strobes arrive together
    always_comb begin
        sel = reg_decode(io_addr);
        acc = PPC_ACC_IDLE;
        if (io_wr) begin
            acc = PPC_ACC_WRITE;
        end else if (io_rd) begin
            acc = PPC_ACC_READ;
        end
    end

    // ------------------------------------------------------------
    // control words
    // ------------------------------------------------------------
    ppc_byte_t g1_cw;
    ppc_byte_t g2_cw;
    logic      g1_cw_wr;
    logic      g2_cw_wr;

    assign g1_cw_wr = (acc == PPC_ACC_WRITE) && (sel == PPC_SEL_G1_CTRL);
    assign g2_cw_wr = (acc == PPC_ACC_WRITE) && (sel == PPC_SEL_G2_CTRL);

    ppc_ctrl #(
        .FORCE_MODE0 (1'b0)
    ) u_g1_ctrl (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (g1_cw_wr),
        .wdata   (io_wdata),
        .cw      (g1_cw)
    );

    ppc_ctrl #(
        .FORCE_MODE0 (1'b1)
    ) u_g2_ctrl (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (g2_cw_wr),
        .wdata   (io_wdata),
        .cw      (g2_cw)
    );

    // ------------------------------------------------------------
    // group 1 third port role
    // ------------------------------------------------------------
    // strobed modes are not built: the port stays mode 0,
    // is only reported as no full path,
    // and the interrupt lines stay routed
    always_comb begin
        third_full_path = !g1_cw[`PPC_CW_A_MODE_HI]
                       && !g1_cw[`PPC_CW_A_MODE_LO]
                       && !g1_cw[`PPC_CW_B_MODE];
        third_port_line_zero  = third_full_path;
        third_port_line_three = third_full_path;
        first_irq_connect     = !third_full_path;
        second_irq_connect    = !third_full_path;
    end

    // ------------------------------------------------------------
    // port directions
    // ------------------------------------------------------------
    logic [WIDTH-1:0] dir [NPORT];
    localparam int HALF = WIDTH / 2;

    always_comb begin
        dir[0] = dir_fill(g1_cw[`PPC_CW_FIRST_DIR]);
        dir[1] = dir_fill(g1_cw[`PPC_CW_SECOND_DIR]);
        // no nibble split on group 1: input only when both bits set
        dir[2] = dir_fill(g1_cw[`PPC_CW_UPPER_DIR]
                       && g1_cw[`PPC_CW_LOWER_DIR]);
        dir[3] = dir_fill(g2_cw[`PPC_CW_FIRST_DIR]);
        dir[4] = dir_fill(g2_cw[`PPC_CW_SECOND_DIR]);
        // each nibble follows its own bit
        dir[5] = {{(WIDTH-HALF){g2_cw[`PPC_CW_UPPER_DIR]}},
                  {HALF{g2_cw[`PPC_CW_LOWER_DIR]}}};
    end

    // ------------------------------------------------------------
    // port write enables and data
    // ------------------------------------------------------------
    logic [WIDTH-1:0] pin_in  [NPORT];
    logic [WIDTH-1:0] pin_out [NPORT];
    logic [WIDTH-1:0] pin_oe  [NPORT];
    logic [WIDTH-1:0] rd_val  [NPORT];
    logic [WIDTH-1:0] wdat    [NPORT];
    logic             wen     [NPORT];
    logic             is_wr;
    logic             g1_bsr;
    logic             g2_bsr;

    always_comb begin
        is_wr  = (acc == PPC_ACC_WRITE);
        g1_bsr = g1_cw_wr && !io_wdata[`PPC_CW_MODE_SET];
        g2_bsr = g2_cw_wr && !io_wdata[`PPC_CW_MODE_SET];
        for (int i = 0; i < NPORT; i++) begin
            wdat[i] = io_wdata[WIDTH-1:0];
        end
        wen[0] = is_wr && (sel == PPC_SEL_G1_FIRST);
        wen[1] = is_wr && (sel == PPC_SEL_G1_SECOND);
        wen[2] = (is_wr && (sel == PPC_SEL_G1_THIRD)) || g1_bsr;
        wen[3] = is_wr && (sel == PPC_SEL_G2_FIRST);
        wen[4] = is_wr && (sel == PPC_SEL_G2_SECOND);
        wen[5] = (is_wr && (sel == PPC_SEL_G2_THIRD)) || g2_bsr;
        if (g1_bsr) begin
            wdat[2] = bit_cmd(pin_out[2], io_wdata);
        end
        if (g2_bsr) begin
            wdat[5] = bit_cmd(pin_out[5], io_wdata);
        end
    end

    assign pin_in[0] = g1_first_in;
    assign pin_in[1] = g1_second_in;
    assign pin_in[2] = g1_third_in;
    assign pin_in[3] = g2_first_in;
    assign pin_in[4] = g2_second_in;
    assign pin_in[5] = g2_third_in;

    // ------------------------------------------------------------
    // port instances
    // ------------------------------------------------------------
    // each port owns its latch, so direction of one never limits
    // another within the group
    generate
        for (genvar p = 0; p < NPORT; p++) begin : g_port
            ppc_port #(
                .WIDTH (WIDTH)
            ) u_port (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .wr_en    (wen[p]),
                .wdata    (wdat[p]),
                .dir_in   (dir[p]),
                .pin_in   (pin_in[p]),
                .pin_out  (pin_out[p]),
                .pin_oe   (pin_oe[p]),
                .rd_value (rd_val[p])
            );
        end
    endgenerate

    assign g1_first_out  = pin_out[0];
    assign g1_first_oe   = pin_oe[0];
    assign g1_second_out = pin_out[1];
    assign g1_second_oe  = pin_oe[1];
    assign g1_third_out  = pin_out[2];
    assign g1_third_oe   = pin_oe[2];
    assign g2_first_out  = pin_out[3];
    assign g2_first_oe   = pin_oe[3];
    assign g2_second_out = pin_out[4];
    assign g2_second_oe  = pin_oe[4];
    assign g2_third_out  = pin_out[5];
    assign g2_third_oe   = pin_oe[5];

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // control words are write-only and read as zero;
    // read data is registered so the bus sees a flop
    ppc_byte_t rdata_q;
    ppc_byte_t next_rdata_q;
    logic      rvalid_q;
    logic      next_rvalid_q;

    always_comb begin
        next_rvalid_q = (acc == PPC_ACC_READ);
        next_rdata_q  = rdata_q;
        if (acc == PPC_ACC_READ) begin
            next_rdata_q = `PPC_UNMAPPED_READ;
            if (sel == PPC_SEL_G1_FIRST) begin
                next_rdata_q = 8'(rd_val[0]);
            end else if (sel == PPC_SEL_G1_SECOND) begin
                next_rdata_q = 8'(rd_val[1]);
            end else if (sel == PPC_SEL_G1_THIRD) begin
                next_rdata_q = 8'(rd_val[2]);
            end else if (sel == PPC_SEL_G2_FIRST) begin
                next_rdata_q = 8'(rd_val[3]);
            end else if (sel == PPC_SEL_G2_SECOND) begin
                next_rdata_q = 8'(rd_val[4]);
            end else if (sel == PPC_SEL_G2_THIRD) begin
                next_rdata_q = 8'(rd_val[5]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q  <= `PPC_RDATA_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= next_rdata_q;
            rvalid_q <= next_rvalid_q;
        end
    end

    assign io_rdata  = rdata_q;
    assign io_rvalid = rvalid_q;

endmodule

// ===== include/ppc_regs.svh
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// ----------------------------------------------------------------
// register offsets in processor i/o space
// ----------------------------------------------------------------
`define PPC_G1_FIRST_OFF   8'he4
`define PPC_G1_SECOND_OFF  8'he5
`define PPC_G1_THIRD_OFF   8'he6
`define PPC_G1_CTRL_OFF    8'he7
`define PPC_G2_FIRST_OFF   8'he8
`define PPC_G2_SECOND_OFF  8'he9
`define PPC_G2_THIRD_OFF   8'hea
`define PPC_G2_CTRL_OFF    8'heb

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define PPC_CW_MODE_SET    7
`define PPC_CW_A_MODE_HI   6
`define PPC_CW_A_MODE_LO   5
`define PPC_CW_FIRST_DIR   4
`define PPC_CW_UPPER_DIR   3
`define PPC_CW_B_MODE      2
`define PPC_CW_SECOND_DIR  1
`define PPC_CW_LOWER_DIR   0
`define PPC_CW_BSR_SEL_HI  3
`define PPC_CW_BSR_SEL_LO  1
`define PPC_CW_BSR_VAL     0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPC_CW_RESET       8'h9b
`define PPC_LATCH_RESET    8'h00
`define PPC_RDATA_RESET    8'h00
`define PPC_UNMAPPED_READ  8'h00

`endif

// ===== include/ppc_pkg.sv
package ppc_pkg;

    typedef logic [7:0] ppc_byte_t;

    typedef enum {
        PPC_ACC_IDLE,
        PPC_ACC_READ,
        PPC_ACC_WRITE
    } ppc_access_e;

    typedef enum {
        PPC_SEL_G1_FIRST,
        PPC_SEL_G1_SECOND,
        PPC_SEL_G1_THIRD,
        PPC_SEL_G1_CTRL,
        PPC_SEL_G2_FIRST,
        PPC_SEL_G2_SECOND,
        PPC_SEL_G2_THIRD,
        PPC_SEL_G2_CTRL,
        PPC_SEL_NONE
    } ppc_sel_e;

endpackage

// ===== src/ppc_port.sv
`timescale 1ns/1ps
`include "ppc_regs.svh"

module ppc_port #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,      // system clock
    input  wire logic             sys_rst,  // sync reset, active high
    input  wire logic             wr_en,    // load output latch
    input  wire logic [WIDTH-1:0] wdata,    // value for output latch
    input  wire logic [WIDTH-1:0] dir_in,   // per bit: 1 input, 0 output
    input  wire logic [WIDTH-1:0] pin_in,   // pin levels
    output logic      [WIDTH-1:0] pin_out,  // output latch
    output logic      [WIDTH-1:0] pin_oe,   // drive enable per bit
    output logic      [WIDTH-1:0] rd_value  // value seen by a read
);
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] next_latch_q;

    // ------------------------------------------------------------
    // output latch
    // ------------------------------------------------------------
    // latch keeps loading even while input, so a value written first
    // appears the moment the bit turns to output
    always_comb begin
        next_latch_q = latch_q;
        if (wr_en) begin
            next_latch_q = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latch_q <= WIDTH'(`PPC_LATCH_RESET);
        end else begin
            latch_q <= next_latch_q;
        end
    end

    // ------------------------------------------------------------
    // pins and read value
    // ------------------------------------------------------------
    assign pin_out = latch_q;
    assign pin_oe  = ~dir_in;
    // input bits show the pin, output bits the latch
    assign rd_value = (dir_in & pin_in) | (~dir_in & latch_q);

endmodule

// ===== src/ppc_ctrl.sv
`timescale 1ns/1ps
`include "ppc_regs.svh"

module ppc_ctrl #(
    parameter bit FORCE_MODE0 = 1'b0
) (
    input  wire logic              clk,     // system clock
    input  wire logic              sys_rst, // sync reset, active high
    input  wire logic              wr_en,   // write to control address
    input  ppc_pkg::ppc_byte_t     wdata,   // written control word
    output ppc_pkg::ppc_byte_t     cw       // current control word
);
    import ppc_pkg::*;

    ppc_byte_t cw_q;
    ppc_byte_t next_cw_q;

    // ------------------------------------------------------------
    // control word register
    // ------------------------------------------------------------
    // words with the mode-set bit clear are bit set/reset commands
    // and leave the stored configuration alone
    always_comb begin
        next_cw_q = cw_q;
        if (wr_en && wdata[`PPC_CW_MODE_SET]) begin
            next_cw_q = wdata;
            if (FORCE_MODE0) begin
                // only mode 0 exists for this group
                next_cw_q[`PPC_CW_A_MODE_HI] = 1'b0;
                next_cw_q[`PPC_CW_A_MODE_LO] = 1'b0;
                next_cw_q[`PPC_CW_B_MODE]    = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cw_q <= `PPC_CW_RESET;
        end else begin
            cw_q <= next_cw_q;
        end
    end

    assign cw = cw_q;

endmodule

// ===== verif/ppc_ext_model.sv
`timescale 1ns/1ps

module ppc_ext_model (
    input  wire logic            clk,     // system clock
    input  wire logic            slow,    // lag pattern by one cycle
    input  wire logic [7:0]      ext_pat, // level the equipment drives
    input  wire logic [5:0][7:0] pin_out, // device latches
    input  wire logic [5:0][7:0] pin_oe,  // device drive enables
    output logic      [5:0][7:0] pin_in   // resolved line levels
);
    logic [7:0] ext_q;
    logic [7:0] ext_now;

    always_ff @(posedge clk) begin
        ext_q <= ext_pat;
    end

    assign ext_now = slow ? ext_q : ext_pat;

    // each port sees its own pattern so crossed ports show up
    always_comb begin
        for (int p = 0; p < 6; p++) begin
            pin_in[p] = (pin_oe[p] & pin_out[p])
                      | (~pin_oe[p] & (ext_now ^ (8'h11 * p[7:0])));
        end
    end
endmodule

// ===== verif/ppc_top_checker.sv
`timescale 1ns/1ps

module ppc_top_checker
    import ppc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,                  // system clock
    input  wire logic             sys_rst,              // sync reset
    input  ppc_pkg::ppc_byte_t    io_addr,              // address
    input  wire logic             io_rd,                // read strobe
    input  wire logic             io_wr,                // write strobe
    input  ppc_pkg::ppc_byte_t    io_wdata,             // write data
    input  ppc_pkg::ppc_byte_t    io_rdata,             // read data
    input  wire logic             io_rvalid,            // read valid
    input  wire logic [WIDTH-1:0] g1_third_oe,          // g1 third drive
    input  wire logic [WIDTH-1:0] g2_first_oe,          // g2 first drive
    input  wire logic [WIDTH-1:0] g2_first_out,         // g2 first latch
    input  wire logic [WIDTH-1:0] g2_second_in,         // g2 second pins
    input  wire logic [WIDTH-1:0] g2_second_oe,         // g2 second drive
    input  wire logic [WIDTH-1:0] g2_third_oe,          // g2 third drive
    input  wire logic             third_full_path,      // 8-bit path
    input  wire logic             third_port_line_zero, // line 0 data
    input  wire logic             third_port_line_three,// line 3 data
    input  wire logic             first_irq_connect,    // irq routed
    input  wire logic             second_irq_connect    // irq routed
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

// ----------------------------------------------------------------
// bus and direction checks
// ----------------------------------------------------------------
    wire rd_only = io_rd && !io_wr;
    wire g1_mode = io_wr && io_addr == 8'he7 && io_wdata[7];
    wire g2_mode = io_wr && io_addr == 8'heb && io_wdata[7];

    rd_valid_a: assert property (rd_only |=> io_rvalid)
        else $error("read not answered");
    no_valid_a: assert property (!rd_only |=> !io_rvalid)
        else $error("stray read valid");
    pin_read_a: assert property (rd_only && io_addr == 8'he9
        && g2_second_oe == '0 |=> io_rdata == $past(g2_second_in))
        else $error("input read not pin level");
    ctrl_read_a: assert property (rd_only && io_addr == 8'heb
        |=> io_rdata == 8'h00) else $error("control read not zero");
    latch_load_a: assert property (io_wr && io_addr == 8'he8
        |=> g2_first_out == $past(io_wdata)) else $error("latch not loaded");
    g1_third_a: assert property (g1_mode |=> g1_third_oe
        == {8{!($past(io_wdata[3]) && $past(io_wdata[0]))}})
        else $error("group 1 third direction");
    g2_first_a: assert property (g2_mode
        |=> g2_first_oe == {8{~$past(io_wdata[4])}})
        else $error("group 2 first direction");
    g2_second_a: assert property (g2_mode
        |=> g2_second_oe == {8{~$past(io_wdata[1])}})
        else $error("group 2 second direction");
    g2_third_a: assert property (g2_mode
        |=> g2_third_oe == {{4{~$past(io_wdata[3])}},
        {4{~$past(io_wdata[0])}}}) else $error("group 2 third direction");
    full_path_a: assert property (g1_mode |=> third_full_path
        == ($past(io_wdata[6:5]) == 2'b00 && !$past(io_wdata[2])))
        else $error("full path flag");
    path_lines_a: assert property (third_port_line_zero == third_full_path
        && third_port_line_three == third_full_path
        && first_irq_connect != third_full_path
        && second_irq_connect != third_full_path) else $error("path lines");

    cover property (g2_mode && io_wdata == 8'h88);
    cover property (io_rd && io_wr);
    cover property ($fell(third_full_path));
endmodule

bind ppc_top ppc_top_checker #(.WIDTH(WIDTH)) u_ppc_top_checker (
    .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .g1_third_oe(g1_third_oe),
    .g2_first_oe(g2_first_oe), .g2_first_out(g2_first_out),
    .g2_second_in(g2_second_in), .g2_second_oe(g2_second_oe),
    .g2_third_oe(g2_third_oe), .third_full_path(third_full_path),
    .third_port_line_zero(third_port_line_zero),
    .third_port_line_three(third_port_line_three),
    .first_irq_connect(first_irq_connect),
    .second_irq_connect(second_irq_connect));

// ===== verif/dual_group_parallel_port_config_tb.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    bad_count++; $display("Error %0t: mismatch got %h exp %h", $time, \
    got, exp); end end

module dual_group_parallel_port_config_tb;
    import ppc_pkg::*;
    logic            clk = 1'b0, sys_rst = 1'b1, io_rvalid;
    logic            io_rd = 1'b0, io_wr = 1'b0, slow = 1'b0;
    logic            third_full_path, line_zero, line_three;
    logic            irq_one, irq_two;
    logic [5:0][7:0] pin_in_v, out_v, oe_v;
    ppc_byte_t       io_addr = 8'h00, io_wdata = 8'h00, io_rdata;
    ppc_byte_t       ext_pat = 8'h3c, cw1 = 8'h9b, cw2 = 8'h9b;
    ppc_byte_t       latch [6] = '{default: 8'h00};
    ppc_byte_t       g1w [5] = '{8'h89, 8'h80, 8'h88, 8'h81, 8'h99};
    logic [31:0]     rnd = 32'hc3c75652;
    int              bad_count, n_compared, p;

    ppc_top u_ppc_top (
        .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd),
        .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid),
        .g1_first_in(pin_in_v[0]), .g1_first_out(out_v[0]),
        .g1_first_oe(oe_v[0]), .g1_second_in(pin_in_v[1]),
        .g1_second_out(out_v[1]), .g1_second_oe(oe_v[1]),
        .g1_third_in(pin_in_v[2]), .g1_third_out(out_v[2]),
        .g1_third_oe(oe_v[2]), .g2_first_in(pin_in_v[3]),
        .g2_first_out(out_v[3]), .g2_first_oe(oe_v[3]),
        .g2_second_in(pin_in_v[4]), .g2_second_out(out_v[4]),
        .g2_second_oe(oe_v[4]), .g2_third_in(pin_in_v[5]),
        .g2_third_out(out_v[5]), .g2_third_oe(oe_v[5]),
        .third_full_path(third_full_path),
        .third_port_line_zero(line_zero),
        .third_port_line_three(line_three),
        .first_irq_connect(irq_one), .second_irq_connect(irq_two));

    ppc_ext_model u_ppc_ext_model (
        .clk(clk), .slow(slow), .ext_pat(ext_pat), .pin_out(out_v),
        .pin_oe(oe_v), .pin_in(pin_in_v));

    initial forever #12.5 clk = ~clk;

// ----------------------------------------------------------------
// expectations
// ----------------------------------------------------------------
    function automatic ppc_byte_t addr_of(int q);
        return (q < 3) ? 8'he4 + 8'(q) : 8'he5 + 8'(q);
    endfunction

    function automatic ppc_byte_t oe_of(int q);
        case (q)
            0: return {8{~cw1[4]}};
            1: return {8{~cw1[1]}};
            2: return (cw1[3] && cw1[0]) ? 8'h00 : 8'hff;
            3: return {8{~cw2[4]}};
            4: return {8{~cw2[1]}};
            default: return {{4{~cw2[3]}}, {4{~cw2[0]}}};
        endcase
    endfunction

    function automatic ppc_byte_t exp_rd(int q);
        ppc_byte_t e;
        e = ext_pat ^ (8'h11 * 8'(q));
        return (latch[q] & oe_of(q)) | (e & ~oe_of(q));
    endfunction

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    task automatic wr(input ppc_byte_t a, input ppc_byte_t d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        for (int q = 0; q < 6; q++)
            if (a == addr_of(q))
                latch[q] = d;
        if ((a == 8'he7 || a == 8'heb) && !d[7])
            latch[(a == 8'heb) ? 5 : 2][d[3:1]] = d[0];
        else if (a == 8'he7)
            cw1 = d;
        else if (a == 8'heb)
            cw2 = d;
    endtask

    task automatic rd(input ppc_byte_t a, input ppc_byte_t exp);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        @(negedge clk);
        `CHK(io_rvalid, 1'b1)
        `CHK(io_rdata, exp)
    endtask

    task automatic check_all();
        logic fp;
        @(negedge clk);
        fp = (cw1[6:5] == 2'b00) && !cw1[2];
        for (int q = 0; q < 6; q++) begin
            `CHK(oe_v[q], oe_of(q))
            `CHK(out_v[q], latch[q])
        end
        `CHK(third_full_path, fp)
        `CHK({line_zero, line_three}, {fp, fp})
        `CHK({irq_one, irq_two}, {!fp, !fp})
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // run is about seven hundred cycles; wide margin
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

// ----------------------------------------------------------------
// scenarios
// ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        check_all();
        for (int q = 0; q < 6; q++)
            rd(addr_of(q), exp_rd(q));
        for (int k = 0; k < 4; k++) begin
            wr(8'heb, {3'b100, k[0] ^ k[1], k[1],
                       1'b0, ~k[0], k[0]});
            wr(8'hea, 8'h5a + 8'(k));
            check_all();
            rd(8'hea, exp_rd(5));
            rd(8'he9, exp_rd(4));
        end
        for (int i = 0; i < 5; i++) begin
            wr(8'he7, g1w[i]);
            wr(8'he6, 8'ha5 ^ 8'(i));
            check_all();
            rd(8'he6, exp_rd(2));
        end
        // strobed word flips the reporting outputs and sets all group 1 ports to output
        wr(8'he7, 8'ha4);
        check_all();
        wr(8'he7, 8'h9b);
        wr(8'heb, 8'he6);
        check_all();
        rd(8'he8, exp_rd(3));
        rd(8'he9, exp_rd(4));
        @(posedge clk);
        io_rd <= 1'b1;
        wr(8'he8, 8'h3c);
        io_rd <= 1'b0;
        @(negedge clk);
        `CHK(io_rvalid, 1'b0)
        wr(8'he3, 8'hff);
        wr(8'hec, 8'hff);
        check_all();
        rd(8'hec, 8'h00);
        rd(8'he7, 8'h00);
        rd(8'heb, 8'h00);
        @(posedge clk);
        slow <= 1'b1;
        ext_pat <= 8'hc6;
        wr(8'heb, 8'h9b);
        rd(8'hea, exp_rd(5));
        @(posedge clk);
        slow <= 1'b0;
        for (int n = 0; n < 300; n++) begin
            rnd = lfsr(rnd);
            p = int'(rnd[6:4]) % 6;
            case (rnd[1:0])
                2'd0: wr(rnd[2] ? 8'heb : 8'he7,
                         rnd[15] ? rnd[15:8] & 8'h9b : rnd[15:8]);
                2'd1: wr(addr_of(p), rnd[23:16]);
                2'd2: rd(addr_of(p), exp_rd(p));
                default: begin
                    @(posedge clk);
                    ext_pat <= rnd[31:24];
                end
            endcase
            check_all();
        end
        wrap_up();
    end
endmodule
